/* bench/sswr_ctrl_chk.sv */
/* sswr_ctrl_chk: port checker for sswr_ctrl.
   assumes: bound to sswr_ctrl, four-clock lines from the model. */
`timescale 1ns/1ps
module sswr_ctrl_chk
    import sswr_pkg::*;
#(
    parameter int WIN_W = SSWR_WIN_BITS
) (
    // register port
    input wire logic             clk,
    input wire logic             rst,
    input wire logic             clk_en,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [7:0]       reg_addr,
    input wire logic [7:0]       reg_wdata,
    input wire logic [7:0]       reg_rdata,
    // markers and pins
    input wire logic             rows_all_integrating,
    input wire logic             line_tick,
    input wire logic             readout_minus_line,
    input wire logic             ext_trigger_in,
    input wire logic             frame_trigger,
    input wire logic             strobe_out,
    input wire logic             single_frame_rolling,
    input wire logic [WIN_W-1:0] win_row_start
);
    // shadow control byte, request bit dropped as it self-clears
    logic [7:0] ctl_q;
    wire wr42 = clk_en && reg_wr && reg_addr == SSWR_ADDR_SYNC_STROBE;
    wire auto = clk_en && !reg_wr && ctl_q[3] && !ctl_q[5] && single_frame_rolling;
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_q <= SSWR_RST_SYNC_STROBE;
        end else if (wr42) begin
            ctl_q <= {2'h0, reg_wdata[5:1], 1'b0};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_start(w);
        auto && ctl_q[4] == w && rows_all_integrating && !strobe_out;
    endsequence
    a_req_one_pulse: assert property (wr42 && reg_wdata[2:0] == 3'h1 ##1 clk_en && !reg_wr
        |-> frame_trigger ##1 !frame_trigger) else $error("sync pulse width wrong");
    a_req_reads_zero: assert property (reg_rd && clk_en && reg_addr == SSWR_ADDR_SYNC_STROBE
        |=> reg_rdata[0] == 1'b0 && reg_rdata[7:6] == 2'h0) else $error("request bit read back");
    a_hold_high: assert property (ctl_q[1] && !ctl_q[2] |-> frame_trigger)
        else $error("hold did not keep trigger");
    a_ext_follow: assert property (ctl_q[2] |-> frame_trigger == ext_trigger_in)
        else $error("trigger not from pin");
    a_auto_start: assert property (s_start(1'b0) or s_start(1'b1) |=> strobe_out)
        else $error("auto strobe did not start");
    a_narrow_line: assert property (s_start(1'b0) ##1 (auto && !line_tick)[*3] ##1 auto && line_tick
        |-> strobe_out ##1 !strobe_out) else $error("narrow strobe not one line");
    a_wide_stop: assert property (s_start(1'b1) ##1 (auto && !readout_minus_line)[*8]
        ##1 (auto && !readout_minus_line)[*3] ##1 auto && readout_minus_line
        |-> strobe_out ##1 !strobe_out) else $error("wide strobe end wrong");
    a_force_high: assert property (ctl_q[5] |-> strobe_out)
        else $error("forced strobe low");
    a_row_start_lo: assert property (clk_en && reg_wr && reg_addr == SSWR_ADDR_ROW_START_LO
        |=> win_row_start[7:0] == $past(reg_wdata)) else $error("row start low byte wrong");
endmodule
bind sswr_ctrl sswr_ctrl_chk #(.WIN_W(WIN_W)) u_chk (.*);

/* bench/sswr_ctrl_tb.sv */
/* sswr_ctrl_tb: self-checking bench for sswr_ctrl.
   assumes: frame model on the markers, checker bound by its own file. */
`timescale 1ns/1ps
module sswr_ctrl_tb
    import sswr_pkg::*;
;
    localparam int RAI = 4;
    localparam int RML = 16;
    logic        clk, rst, clk_en, reg_wr, reg_rd, go, ext_level, frame_trigger, strobe_out;
    logic        rows_all_integrating, line_tick, readout_minus_line, ext_trigger_in, single_frame_rolling;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [10:0] win_row_start, win_col_start, win_row_size, win_col_size;
    int          bad_count = 0, comparisons = 0, cycles = 0;
    sswr_ctrl u_sswr_ctrl (.clk, .rst, .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .rows_all_integrating, .line_tick, .readout_minus_line, .ext_trigger_in,
        .frame_trigger, .strobe_out, .win_row_start, .win_col_start, .win_row_size,
        .win_col_size, .single_frame_rolling);
    sswr_frame_model #(.RAI(RAI), .RML(RML)) u_sswr_frame_model (.clk, .rst, .go, .ext_level,
        .rows_all_integrating, .line_tick, .readout_minus_line, .ext_trigger_in);
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(negedge clk);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge clk);
        reg_rd = 1'b0;
        chk("reg_rdata", 16'(exp), 16'(reg_rdata));
    endtask
    task automatic t_reset;
        chk("frame_trigger", 16'h1, 16'(frame_trigger));
        chk("win_row_start", 16'h0010, 16'(win_row_start));
        rd(SSWR_ADDR_SYNC_STROBE, SSWR_RST_SYNC_STROBE);
        rd(SSWR_ADDR_CAPTURE_MODE, SSWR_RST_CAPTURE_MODE);
        rd(8'h50, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_sync;
        wr(SSWR_ADDR_SYNC_STROBE, 8'h01);
        chk("frame_trigger", 16'h1, 16'(frame_trigger));
        @(negedge clk);
        chk("frame_trigger", 16'h0, 16'(frame_trigger));
        rd(SSWR_ADDR_SYNC_STROBE, 8'h00);
        wr(SSWR_ADDR_SYNC_STROBE, 8'h04);
        ext_level = 1'b1;
        @(negedge clk);
        chk("frame_trigger", 16'h1, 16'(frame_trigger));
        ext_level = 1'b0;
        @(negedge clk);
        chk("frame_trigger", 16'h0, 16'(frame_trigger));
        $display("sync test done");
    endtask
    task automatic t_window;
        wr(SSWR_ADDR_ROW_START_HI, 8'hFC);
        wr(SSWR_ADDR_ROW_START_LO, 8'h17);
        wr(SSWR_ADDR_COL_START_HI, 8'h05);
        wr(SSWR_ADDR_COL_START_LO, 8'h0F);
        wr(SSWR_ADDR_ROW_SIZE_HI, 8'h04);
        wr(SSWR_ADDR_ROW_SIZE_LO, 8'h17);
        wr(SSWR_ADDR_COL_SIZE_HI, 8'h07);
        wr(SSWR_ADDR_COL_SIZE_LO, 8'hFF);
        chk("win_row_start", 16'h0417, 16'(win_row_start));
        chk("win_col_start", 16'h050F, 16'(win_col_start));
        chk("win_row_size", 16'h0417, 16'(win_row_size));
        chk("win_col_size", 16'h07FF, 16'(win_col_size));
        rd(SSWR_ADDR_ROW_START_HI, 8'h04);
        $display("window test done");
    endtask
    task automatic strobe_run(logic [7:0] mode, logic [7:0] ctl, int exp, string name);
        int n;
        n = 0;
        wr(SSWR_ADDR_CAPTURE_MODE, mode);
        chk("single_frame_rolling", 16'(mode[SSWR_BIT_SINGLE_FRAME]), 16'(single_frame_rolling));
        wr(SSWR_ADDR_SYNC_STROBE, ctl);
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        repeat (24) begin
            n += int'(strobe_out === 1'b1);
            @(negedge clk);
        end
        chk(name, 16'(exp), 16'(n));
        wr(SSWR_ADDR_SYNC_STROBE, 8'h00);
    endtask
    task automatic t_strobe;
        strobe_run(8'h4A, 8'h08, 4, "narrow strobe");
        strobe_run(8'h4A, 8'h18, RML - RAI, "wide strobe");
        strobe_run(8'h0A, 8'h18, 0, "continuous strobe");
        strobe_run(8'h0A, 8'h38, 24, "forced strobe");
        chk("strobe_out", 16'h0, 16'(strobe_out));
        $display("strobe test done");
    endtask
    task automatic t_freeze;
        clk_en = 1'b0;
        wr(SSWR_ADDR_SYNC_STROBE, 8'h21);
        chk("strobe_out", 16'h0, 16'(strobe_out));
        chk("frame_trigger", 16'h0, 16'(frame_trigger));
        clk_en = 1'b1;
        @(negedge clk);
        chk("strobe_out", 16'h0, 16'(strobe_out));
        chk("frame_trigger", 16'h0, 16'(frame_trigger));
        $display("freeze test done");
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            conclude;
        end
    end
    initial begin
        clk_en = 1'b1;
        {rst, reg_wr, reg_rd, go, ext_level, reg_addr, reg_wdata} = {5'h10, 16'h0};
        repeat (12) @(negedge clk);
        rst = 1'b0;
        t_reset;
        t_sync;
        t_window;
        t_strobe;
        t_freeze;
        conclude;
    end
endmodule

/* bench/sswr_frame_model.sv */
/* sswr_frame_model: frame timing core and trigger pin source.
   assumes: go is a one-cycle start from the bench. */
`timescale 1ns/1ps
module sswr_frame_model #(
    parameter int RAI = 4,
    parameter int RML = 16
) (
    // clock and control
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic go,
    input  wire logic ext_level,
    // markers and pin
    output logic      rows_all_integrating,
    output logic      line_tick,
    output logic      readout_minus_line,
    output logic      ext_trigger_in
);
    logic [4:0] cnt_q;
    always_ff @(posedge clk) begin
        if (rst || cnt_q == 5'h14) begin
            cnt_q <= 5'h0;
        end else if (go || cnt_q != 5'h0) begin
            cnt_q <= cnt_q + 5'h1;
        end
    end
    // four-clock line keeps frames short
    assign line_tick            = cnt_q != 5'h0 && cnt_q[1:0] == 2'h0;
    assign rows_all_integrating = cnt_q == 5'(RAI);
    assign readout_minus_line   = cnt_q == 5'(RML);
    assign ext_trigger_in       = ext_level;
endmodule

/* verilog/sswr_ctrl.sv */
/*
 * sswr_ctrl: sync trigger, flash strobe and readout window registers.
 * assumes: register port already decoded from the serial control bus,
 * frame timing core supplies all-rows-integrating, line tick and
 * pre-readout markers as one-cycle pulses on clk.
 */
`timescale 1ns/1ps
module sswr_ctrl
    import sswr_pkg::*;
#(
    parameter int WIN_W = SSWR_WIN_BITS
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             clk_en,
    // register port
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    output logic      [7:0]       reg_rdata,
    // frame timing markers
    input  wire logic             rows_all_integrating,
    input  wire logic             line_tick,
    input  wire logic             readout_minus_line,
    // pins
    input  wire logic             ext_trigger_in,
    output logic                  frame_trigger,
    output logic                  strobe_out,
    // window to readout core
    output logic      [WIN_W-1:0] win_row_start,
    output logic      [WIN_W-1:0] win_col_start,
    output logic      [WIN_W-1:0] win_row_size,
    output logic      [WIN_W-1:0] win_col_size,
    output logic                  single_frame_rolling
);
    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [7:0] capture_q;
    logic [5:1] sync_strobe_q;
    logic       sync_pulse_request_q;
    logic [2:0] row_start_hi_q;
    logic [7:0] row_start_lo_q;
    logic [2:0] row_size_hi_q;
    logic [7:0] row_size_lo_q;
    logic [2:0] col_start_hi_q;
    logic [7:0] col_start_lo_q;
    logic [2:0] col_size_hi_q;
    logic [7:0] col_size_lo_q;
    logic [7:0] rdata_q;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // unmapped addresses hit nothing, so writes there are dropped
    wire wr_en = clk_en & reg_wr;
    wire hit_cap  = (reg_addr == SSWR_ADDR_CAPTURE_MODE);
    wire hit_ss   = (reg_addr == SSWR_ADDR_SYNC_STROBE);
    wire hit_rshi = (reg_addr == SSWR_ADDR_ROW_START_HI);
    wire hit_rslo = (reg_addr == SSWR_ADDR_ROW_START_LO);
    wire hit_rzhi = (reg_addr == SSWR_ADDR_ROW_SIZE_HI);
    wire hit_rzlo = (reg_addr == SSWR_ADDR_ROW_SIZE_LO);
    wire hit_cshi = (reg_addr == SSWR_ADDR_COL_START_HI);
    wire hit_cslo = (reg_addr == SSWR_ADDR_COL_START_LO);
    wire hit_czhi = (reg_addr == SSWR_ADDR_COL_SIZE_HI);
    wire hit_czlo = (reg_addr == SSWR_ADDR_COL_SIZE_LO);

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // capture byte kept whole, only the mode bit drives logic
    always_ff @(posedge clk) begin
        if (rst) begin
            capture_q <= SSWR_RST_CAPTURE_MODE;
        end else if (wr_en & hit_cap) begin
            capture_q <= reg_wdata;
        end
    end

    // bit 0 is not stored, it only fires the request pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_strobe_q <= SSWR_RST_SYNC_STROBE[5:1];
        end else if (wr_en & hit_ss) begin
            sync_strobe_q <= reg_wdata[5:1];
        end
    end

    // ------------------------------------------------------------
    // window byte registers
    // ------------------------------------------------------------
    // hi bytes keep three bits, each byte lands on its own
    // row start pair
    always_ff @(posedge clk) begin
        if (rst) begin
            row_start_hi_q <= SSWR_RST_ZERO[2:0];
        end else if (wr_en & hit_rshi) begin
            row_start_hi_q <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            row_start_lo_q <= SSWR_RST_ROW_START_LO;
        end else if (wr_en & hit_rslo) begin
            row_start_lo_q <= reg_wdata;
        end
    end

    // row size pair
    always_ff @(posedge clk) begin
        if (rst) begin
            row_size_hi_q <= SSWR_RST_ZERO[2:0];
        end else if (wr_en & hit_rzhi) begin
            row_size_hi_q <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            row_size_lo_q <= SSWR_RST_ZERO;
        end else if (wr_en & hit_rzlo) begin
            row_size_lo_q <= reg_wdata;
        end
    end

    // column start pair
    always_ff @(posedge clk) begin
        if (rst) begin
            col_start_hi_q <= SSWR_RST_ZERO[2:0];
        end else if (wr_en & hit_cshi) begin
            col_start_hi_q <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            col_start_lo_q <= SSWR_RST_ZERO;
        end else if (wr_en & hit_cslo) begin
            col_start_lo_q <= reg_wdata;
        end
    end

    // column size pair
    always_ff @(posedge clk) begin
        if (rst) begin
            col_size_hi_q <= SSWR_RST_ZERO[2:0];
        end else if (wr_en & hit_czhi) begin
            col_size_hi_q <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            col_size_lo_q <= SSWR_RST_ZERO;
        end else if (wr_en & hit_czlo) begin
            col_size_lo_q <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // sync request pulse
    // ------------------------------------------------------------
    // frozen cycles stretch the pulse, it lasts one clk_en cycle
    // one-cycle self-clearing request
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_pulse_request_q <= 1'b0;
        end else if (clk_en) begin
            sync_pulse_request_q <= wr_en & hit_ss & reg_wdata[SSWR_BIT_SYNC_REQ];
        end
    end

    // ------------------------------------------------------------
    // control field taps
    // ------------------------------------------------------------
    wire sync_hold_continuous = sync_strobe_q[SSWR_BIT_SYNC_HOLD];
    wire sync_external_allow  = sync_strobe_q[SSWR_BIT_SYNC_EXT];
    wire strobe_auto_en       = sync_strobe_q[SSWR_BIT_STROBE_AUTO];
    wire strobe_auto_wide     = sync_strobe_q[SSWR_BIT_STROBE_WIDTH];
    wire strobe_force         = sync_strobe_q[SSWR_BIT_STROBE_FORCE];

    assign single_frame_rolling = capture_q[SSWR_BIT_SINGLE_FRAME];

    // ------------------------------------------------------------
    // trigger select
    // ------------------------------------------------------------
    // pin select, else request or hold
    assign frame_trigger = sync_external_allow ? ext_trigger_in
                         : (sync_pulse_request_q | sync_hold_continuous);

    // ------------------------------------------------------------
    // strobe sequencer
    // ------------------------------------------------------------
    sswr_strobe_t st_q;
    sswr_strobe_t st_d;
    // auto strobe only in single-frame mode
    wire auto_go = strobe_auto_en & single_frame_rolling & rows_all_integrating;

    always_comb begin
        st_d = st_q;
        case (st_q)
            SSWR_ST_IDLE: begin
                if (auto_go) begin
                    st_d = strobe_auto_wide ? SSWR_ST_MAX : SSWR_ST_LINE;
                end
            end
            SSWR_ST_LINE: begin
                if (line_tick) st_d = SSWR_ST_IDLE;
            end
            SSWR_ST_MAX: begin
                if (readout_minus_line) st_d = SSWR_ST_IDLE;
            end
            default: st_d = SSWR_ST_IDLE;
        endcase
        // a mode change mid-pulse would leave the pin stuck, so abort
        if (!(strobe_auto_en & single_frame_rolling)) st_d = SSWR_ST_IDLE;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= SSWR_ST_IDLE;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // sequencer keeps running under force, so release is clean
    // force overrides auto strobe
    assign strobe_out = strobe_force | (st_q != SSWR_ST_IDLE);

    // ------------------------------------------------------------
    // window assembly
    // ------------------------------------------------------------
    // window hi/lo merge
    assign win_row_start = {row_start_hi_q, row_start_lo_q};
    assign win_col_start = {col_start_hi_q, col_start_lo_q};
    assign win_row_size  = {row_size_hi_q, row_size_lo_q};
    assign win_col_size  = {col_size_hi_q, col_size_lo_q};

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // request bit always reads zero
    // unmapped addresses and unused sync/strobe and window hi bits read as zero, capture byte reads back whole
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = SSWR_RST_ZERO;
        if (hit_cap) begin
            rd_mux = capture_q;
        end else if (hit_ss) begin
            rd_mux = {2'b00, sync_strobe_q, 1'b0};
        end else if (hit_rshi) begin
            rd_mux = {5'b0_0000, row_start_hi_q};
        end else if (hit_rslo) begin
            rd_mux = row_start_lo_q;
        end else if (hit_rzhi) begin
            rd_mux = {5'b0_0000, row_size_hi_q};
        end else if (hit_rzlo) begin
            rd_mux = row_size_lo_q;
        end else if (hit_cshi) begin
            rd_mux = {5'b0_0000, col_start_hi_q};
        end else if (hit_cslo) begin
            rd_mux = col_start_lo_q;
        end else if (hit_czhi) begin
            rd_mux = {5'b0_0000, col_size_hi_q};
        end else if (hit_czlo) begin
            rd_mux = col_size_lo_q;
        end
    end

    // registered, so read data stands until the next read
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= SSWR_RST_ZERO;
        end else if (clk_en & reg_rd) begin
            rdata_q <= rd_mux;
        end
    end

    assign reg_rdata = rdata_q;
endmodule

/* verilog/sswr_pkg.sv */
/*
 * sswr_pkg: register map, field positions and reset values for the
 * sync/strobe control and readout window registers.
 * assumes: 8-bit serial control bus with 8-bit register addresses.
 */
package sswr_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SSWR_ADDR_CAPTURE_MODE   = 8'h40;
    localparam logic [7:0] SSWR_ADDR_SYNC_STROBE    = 8'h42;
    localparam logic [7:0] SSWR_ADDR_ROW_START_HI   = 8'h45;
    localparam logic [7:0] SSWR_ADDR_ROW_START_LO   = 8'h46;
    localparam logic [7:0] SSWR_ADDR_ROW_SIZE_HI    = 8'h47;
    localparam logic [7:0] SSWR_ADDR_ROW_SIZE_LO    = 8'h48;
    localparam logic [7:0] SSWR_ADDR_COL_START_HI   = 8'h49;
    localparam logic [7:0] SSWR_ADDR_COL_START_LO   = 8'h4A;
    localparam logic [7:0] SSWR_ADDR_COL_SIZE_HI    = 8'h4B;
    localparam logic [7:0] SSWR_ADDR_COL_SIZE_LO    = 8'h4C;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SSWR_BIT_SYNC_REQ     = 0;
    localparam int SSWR_BIT_SYNC_HOLD    = 1;
    localparam int SSWR_BIT_SYNC_EXT     = 2;
    localparam int SSWR_BIT_STROBE_AUTO  = 3;
    localparam int SSWR_BIT_STROBE_WIDTH = 4;
    localparam int SSWR_BIT_STROBE_FORCE = 5;
    localparam int SSWR_BIT_SINGLE_FRAME = 6;
    localparam int SSWR_HI_BITS          = 3;
    localparam int SSWR_WIN_BITS         = 11;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SSWR_RST_SYNC_STROBE  = 8'h02;
    localparam logic [7:0] SSWR_RST_CAPTURE_MODE = 8'h0A;
    localparam logic [7:0] SSWR_RST_ROW_START_LO = 8'h10;
    localparam logic [7:0] SSWR_RST_ZERO         = 8'h00;
    // ------------------------------------------------------------
    // strobe sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SSWR_ST_IDLE = 2'b00,
        SSWR_ST_LINE = 2'b01,
        SSWR_ST_MAX  = 2'b10
    } sswr_strobe_t;
endpackage
